// *** rtl/pcfg_pkg.sv ***
// Package with the register map, field positions and reset values of the port 0 pin block.
package pcfg_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_PORT_DATA        = 6'h00;
    localparam logic [5:0] IDX_CLOCK_IN_CFG     = 6'h05;
    localparam logic [5:0] IDX_CLOCK_OUT_CFG    = 6'h06;
    localparam logic [5:0] IDX_EDGE_IRQ0_CFG    = 6'h07;
    localparam logic [5:0] IDX_EDGE_IRQ1_CFG    = 6'h08;
    localparam logic [5:0] IDX_EDGE_IRQ2_CFG    = 6'h09;
    localparam logic [5:0] IDX_TIMER_IO0_CFG    = 6'h0a;
    localparam logic [5:0] IDX_TIMER_IO1_CFG    = 6'h0b;
    localparam logic [5:0] IDX_CLOCK_PIN_CTRL   = 6'h1f;

    // ------------------------------------------------------------
    // Pin configuration fields
    // ------------------------------------------------------------
    localparam int BIT_OUT_EN      = 0;
    localparam int BIT_PULL_UP     = 1;
    localparam int BIT_OPEN_DRAIN  = 2;
    localparam int BIT_HIGH_SINK   = 3;
    localparam int BIT_TTL_THRESH  = 4;
    localparam int BIT_ACT_LOW     = 5;
    localparam int BIT_IRQ_EN      = 6;
    localparam int BIT_ALT_OUT     = 7;

    // ------------------------------------------------------------
    // Clock pin control fields
    // ------------------------------------------------------------
    localparam int BIT_CLK_SEL_LO  = 0;
    localparam int BIT_SER_ALT0    = 4;
    localparam int BIT_SER_ALT1    = 5;
    localparam int BIT_XOSC_ON     = 7;

    // ------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_CLOCK_IN   = 8'h7f;
    localparam logic [7:0] MASK_CLOCK_OUT  = 8'hff;
    localparam logic [7:0] MASK_EDGE_IRQ   = 8'h37;
    localparam logic [7:0] MASK_TIMER_IO   = 8'hf7;
    localparam logic [7:0] MASK_CLOCK_CTRL = 8'hb3;
    localparam logic [7:0] RST_CFG         = 8'h00;
    localparam logic [7:0] RST_DATA        = 8'h00;

    // ------------------------------------------------------------
    // Pin numbers of the shared functions
    // ------------------------------------------------------------
    localparam int PIN_CLK_IN   = 0;
    localparam int PIN_CLK_OUT  = 1;
    localparam int PIN_IRQ0     = 2;
    localparam int PIN_TIMER0   = 5;
    localparam int PIN_TIMER1   = 6;

    typedef enum logic {PCFG_IDLE, PCFG_ACK} pcfg_bus_e;

endpackage

// *** rtl/pcfg_port0.sv ***
// Port 0 pin configuration block with an APB register slave.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// - Polarity bit zero active high, one low.
// - Edge pins: rising edge or falling edge.
// - Threshold bit selects TTL, CMOS after reset.
// - High sink bit drives strength select.
// - Open drain: one floats, zero drives low.
// - Pull-up bit enables pin pull-up.
// - Output enable bit turns driver on.
// - Oscillator on forces clock pin drivers off.
// - Oscillator on ignores clock pin configuration.
// - Serial alternate select hands enable to serial.
// - Clock out bit drives selected clock.
// - Edge pins feed three separate interrupt lines.
// - Output edge pin raises interrupt by data write.
// - Polarity toggle may raise a spurious edge.
// - Timer pins capture inputs or pulse outputs.
// - Timer pin output without pulse loops data.
// - Timer pin 0 outputs ungated interval tick.
// - Timer pin 1 outputs ungated interval interrupt.
// - Edge pins have consecutive configuration registers.
// - Timer pins have consecutive configuration registers.
// - Enabled pin interrupts work in either direction.
// - Data write sets outputs, read returns pins.
// ----------------------------------------------------------------
module pcfg_port0
    import pcfg_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Port pins
    input  wire logic [7:0]        pin_in,
    output logic      [7:0]        pin_out,
    output logic      [7:0]        pin_oe,
    output logic      [7:0]        pull_up_en,
    output logic      [7:0]        ttl_sel,
    output logic      [7:0]        high_sink_sel,
    // Clock sources for the clock out pin
    input  wire logic [3:0]        clk_src,
    // Timer side
    input  wire logic              tick_1024us,
    input  wire logic              pit_irq,
    output logic      [1:0]        timer_capture_in,
    // Serial port pins
    input  wire logic [1:0]        spi_oe,
    input  wire logic [1:0]        spi_out,
    output logic      [1:0]        serial_pin_oe,
    output logic      [1:0]        serial_pin_out,
    // Interrupt controller
    output logic      [2:0]        edge_irq,
    output logic      [7:0]        port_irq
);
    import pcfg_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pcfg_bus_e       st;
        logic            pready;
        logic            pslverr;
        logic [7:0]      prdata;
        logic [7:0]      data;
        logic [6:0][7:0] cfg;
        logic [7:0]      ctl;
        logic [7:0]      pin_s1;
        logic [7:0]      pin_s2;
        logic [7:0]      prev_lvl;
        logic [3:0]      clk_s1;
        logic [3:0]      clk_s2;
        logic [7:0]      pin_out;
        logic [7:0]      pin_oe;
        logic [7:0]      pull_up;
        logic [7:0]      ttl;
        logic [7:0]      hsink;
        logic [1:0]      cap_in;
        logic [1:0]      ser_oe;
        logic [1:0]      ser_out;
        logic [2:0]      edge_irq;
        logic [7:0]      port_irq;
        logic [1:0]      fill;
    } pcfg_state_s;

    pcfg_state_s s_ff;
    pcfg_state_s nxt_s;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // The index decode needs six address bits above the byte lanes.
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_addr_w_check
        $error("ADDR_W must lie between 8 and 32.");
    end

    // Writable bits of each register, so reserved bits read back as zero.
    function automatic logic [7:0] reg_mask(input logic [5:0] idx);
        case (idx)
            IDX_PORT_DATA:      reg_mask = 8'hff;
            IDX_CLOCK_IN_CFG:   reg_mask = MASK_CLOCK_IN;
            IDX_CLOCK_OUT_CFG:  reg_mask = MASK_CLOCK_OUT;
            IDX_EDGE_IRQ0_CFG,
            IDX_EDGE_IRQ1_CFG,
            IDX_EDGE_IRQ2_CFG:  reg_mask = MASK_EDGE_IRQ;
            IDX_TIMER_IO0_CFG,
            IDX_TIMER_IO1_CFG:  reg_mask = MASK_TIMER_IO;
            IDX_CLOCK_PIN_CTRL: reg_mask = MASK_CLOCK_CTRL;
            default:            reg_mask = 8'h00;
        endcase
    endfunction

    function automatic logic reg_hit(input logic [5:0] idx);
        reg_hit = (idx == IDX_PORT_DATA) || (idx == IDX_CLOCK_PIN_CTRL) ||
                  (idx >= IDX_CLOCK_IN_CFG && idx <= IDX_TIMER_IO1_CFG);
    endfunction

    // ------------------------------------------------------------
    // Decoded bus request
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic       bad_addr;
    logic [7:0] lvl;
    logic       xosc;
    logic [7:0] rise;

    assign idx      = paddr[ADDR_W-1:2] > (ADDR_W-2)'(63) ? 6'h3f : 6'(paddr[ADDR_W-1:2]);
    assign bad_addr = !reg_hit(idx) || (paddr[1:0] != 2'h0);
    assign xosc     = s_ff.ctl[BIT_XOSC_ON];

    // Polarity is folded in before the edge detector, so a polarity change alone can look like an edge.
    always_comb
    begin
        lvl = s_ff.pin_s2;
        for (int i = 0; i < 7; i++)
            lvl[i] = s_ff.pin_s2[i] ^ s_ff.cfg[i][BIT_ACT_LOW];
    end

    // Edges count only once the synchroniser and the previous sample hold real pin levels,
    // so a pin that idles high raises no stray interrupt straight after reset.
    assign rise = (s_ff.fill == 2'd3) ? (lvl & ~s_ff.prev_lvl) : 8'h00;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] c;
        logic [7:0] rd;
        logic       drv;
        logic [7:0][7:0] cfg8;
        c     = 8'h00;
        cfg8  = {8'h00, s_ff.cfg};
        rd    = 8'h00;
        drv   = 1'b0;
        nxt_s = s_ff;

        // Two stage synchronisers for pins and clock sources.
        nxt_s.pin_s1   = pin_in;
        nxt_s.pin_s2   = s_ff.pin_s1;
        nxt_s.clk_s1   = clk_src;
        nxt_s.clk_s2   = s_ff.clk_s1;
        nxt_s.prev_lvl = lvl;
        nxt_s.fill     = (s_ff.fill == 2'd3) ? 2'd3 : s_ff.fill + 2'd1;

        // APB: one wait state, then answer.
        case (s_ff.st)
            PCFG_IDLE:
            begin
                nxt_s.pready  = 1'b0;
                nxt_s.pslverr = 1'b0;
                if (psel && penable)
                begin
                    nxt_s.st      = PCFG_ACK;
                    nxt_s.pready  = 1'b1;
                    nxt_s.pslverr = bad_addr;
                    if (bad_addr)
                        rd = 8'h00;
                    else if (idx == IDX_PORT_DATA)
                        rd = s_ff.pin_s2;
                    else if (idx == IDX_CLOCK_PIN_CTRL)
                        rd = s_ff.ctl;
                    else
                        rd = s_ff.cfg[3'(idx - IDX_CLOCK_IN_CFG)];
                    nxt_s.prdata = pwrite ? 8'h00 : rd;
                end
            end
            PCFG_ACK:
            begin
                nxt_s.st      = PCFG_IDLE;
                nxt_s.pready  = 1'b0;
                nxt_s.pslverr = 1'b0;
                if (psel && penable && pwrite && pstrb[0] && !bad_addr)
                begin
                    if (idx == IDX_PORT_DATA)
                        nxt_s.data = pwdata[7:0] & reg_mask(idx);
                    else if (idx == IDX_CLOCK_PIN_CTRL)
                        nxt_s.ctl = pwdata[7:0] & reg_mask(idx);
                    else
                        nxt_s.cfg[3'(idx - IDX_CLOCK_IN_CFG)] = pwdata[7:0] & reg_mask(idx);
                end
            end
            default:
                nxt_s.st = PCFG_IDLE;
        endcase

        // Pin drivers.
        for (int i = 0; i < 8; i++)
        begin
            c = cfg8[i];
            if (i <= PIN_CLK_OUT && xosc)
                c = 8'h00;
            drv = c[BIT_OUT_EN] && !(c[BIT_OPEN_DRAIN] && s_ff.data[i]);
            nxt_s.pin_out[i]  = c[BIT_OPEN_DRAIN] ? 1'b0 : s_ff.data[i];
            nxt_s.pin_oe[i]   = drv;
            nxt_s.pull_up[i]  = c[BIT_PULL_UP];
            nxt_s.ttl[i]      = c[BIT_TTL_THRESH];
            nxt_s.hsink[i]    = c[BIT_HIGH_SINK];
            nxt_s.port_irq[i] = c[BIT_IRQ_EN] && rise[i] &&
                                !(i >= PIN_IRQ0 && i < PIN_TIMER0);
        end

        // Clock out pin carries the selected clock while enabled.
        if (!xosc && s_ff.cfg[PIN_CLK_OUT][BIT_ALT_OUT])
        begin
            nxt_s.pin_out[PIN_CLK_OUT] = s_ff.clk_s2[s_ff.ctl[BIT_CLK_SEL_LO +: 2]];
            nxt_s.pin_oe[PIN_CLK_OUT]  = 1'b1;
        end
        if (xosc)
        begin
            nxt_s.pin_oe[PIN_CLK_IN]  = 1'b0;
            nxt_s.pin_oe[PIN_CLK_OUT] = 1'b0;
        end

        // Dedicated edge interrupts, one line each.
        for (int k = 0; k < 3; k++)
            nxt_s.edge_irq[k] = rise[PIN_IRQ0 + k];

        // Timer pins: pulse out, or capture input from pin or looped data.
        for (int t = 0; t < 2; t++)
        begin
            c = s_ff.cfg[PIN_TIMER0 + t];
            if (c[BIT_OUT_EN] && c[BIT_ALT_OUT])
            begin
                nxt_s.pin_out[PIN_TIMER0 + t] = c[BIT_OPEN_DRAIN] ? 1'b0 : (t == 0 ? tick_1024us : pit_irq);
                nxt_s.pin_oe[PIN_TIMER0 + t]  = !c[BIT_OPEN_DRAIN] || !(t == 0 ? tick_1024us : pit_irq);
            end
            nxt_s.cap_in[t] = (c[BIT_OUT_EN] && !c[BIT_ALT_OUT]) ? s_ff.data[PIN_TIMER0 + t]
                                                               : s_ff.pin_s2[PIN_TIMER0 + t];
        end

        // Serial pins hand their enable to the serial logic when selected.
        for (int p = 0; p < 2; p++)
        begin
            nxt_s.ser_oe[p]  = s_ff.ctl[BIT_SER_ALT0 + p] ? spi_oe[p] : 1'b0;
            nxt_s.ser_out[p] = s_ff.ctl[BIT_SER_ALT0 + p] ? spi_out[p] : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff      <= '0;
            s_ff.st   <= PCFG_IDLE;
            s_ff.data <= RST_DATA;
            s_ff.cfg  <= {7{RST_CFG}};
            s_ff.ctl  <= RST_CFG;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign prdata           = {24'h000000, s_ff.prdata};
    assign pready           = s_ff.pready;
    assign pslverr          = s_ff.pslverr;
    assign pin_out          = s_ff.pin_out;
    assign pin_oe           = s_ff.pin_oe;
    assign pull_up_en       = s_ff.pull_up;
    assign ttl_sel          = s_ff.ttl;
    assign high_sink_sel    = s_ff.hsink;
    assign timer_capture_in = s_ff.cap_in;
    assign serial_pin_oe    = s_ff.ser_oe;
    assign serial_pin_out   = s_ff.ser_out;
    assign edge_irq         = s_ff.edge_irq;
    assign port_irq         = s_ff.port_irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_xosc_drv_off: assert property (xosc |=> (pin_oe[1:0] == 2'b00))
        else $error("Clock pin driven while oscillator on.");
    chk_edge_irq0_set: assert property ((s_ff.fill == 2'd3 && lvl[PIN_IRQ0] && !s_ff.prev_lvl[PIN_IRQ0])
                                        |=> edge_irq[0])
        else $error("Edge interrupt 0 missed.");
    chk_edge_irq0_quiet: assert property (!(lvl[PIN_IRQ0] && !s_ff.prev_lvl[PIN_IRQ0]) |=> !edge_irq[0])
        else $error("Edge interrupt 0 without edge.");
    chk_open_drain_float: assert property ((!xosc && s_ff.cfg[0][BIT_OPEN_DRAIN] && s_ff.data[0]) |=> !pin_oe[0])
        else $error("Open drain pin driven for data one.");
    chk_push_pull_drive: assert property ((!xosc && s_ff.cfg[0][BIT_OUT_EN] && !s_ff.cfg[0][BIT_OPEN_DRAIN])
                                          |=> (pin_oe[0] && pin_out[0] == $past(s_ff.data[0])))
        else $error("Push pull pin not driving data.");
    chk_clock_out_sel: assert property ((!xosc && s_ff.cfg[1][BIT_ALT_OUT])
                                        |=> (pin_oe[1] && pin_out[1] == $past(s_ff.clk_s2[s_ff.ctl[1:0]])))
        else $error("Clock out pin wrong.");
    chk_timer0_pulse: assert property ((s_ff.cfg[PIN_TIMER0][BIT_OUT_EN] &&
                                        s_ff.cfg[PIN_TIMER0][BIT_ALT_OUT] && !s_ff.cfg[PIN_TIMER0][BIT_OPEN_DRAIN])
                                       |=> pin_out[5] == $past(tick_1024us))
        else $error("Timer pin 0 pulse wrong.");
    chk_capture_loop: assert property ((s_ff.cfg[PIN_TIMER0][BIT_OUT_EN] && !s_ff.cfg[PIN_TIMER0][BIT_ALT_OUT])
                                       |=> timer_capture_in[0] == $past(s_ff.data[PIN_TIMER0]))
        else $error("Capture input not looped from data.");
    chk_serial_hand: assert property (s_ff.ctl[BIT_SER_ALT0] |=> serial_pin_oe[0] == $past(spi_oe[0]))
        else $error("Serial enable not passed through.");
    chk_data_read: assert property ((s_ff.st == PCFG_IDLE && psel && penable && !pwrite && paddr == '0)
                                    |=> (pready && prdata[7:0] == $past(s_ff.pin_s2)))
        else $error("Data read not live pin level.");

    chk_ttl_follow: assert property (!xosc |=> ttl_sel[0] == $past(s_ff.cfg[0][BIT_TTL_THRESH]))
        else $error("Threshold select wrong.");
    chk_high_sink: assert property (!xosc |=> high_sink_sel[0] == $past(s_ff.cfg[0][BIT_HIGH_SINK]))
        else $error("High sink select wrong.");
    chk_pull_up_pin: assert property (1'b1 |=> pull_up_en[5] == $past(s_ff.cfg[PIN_TIMER0][BIT_PULL_UP]))
        else $error("Pull-up select wrong.");

    chk_xosc_ignore: assert property (xosc |=> (pull_up_en[1:0] | ttl_sel[1:0] | high_sink_sel[1:0]) == 2'b00)
        else $error("Clock pin setting not ignored.");
    chk_timer_od: assert property (((s_ff.cfg[PIN_TIMER0] & 8'h85) == 8'h85 && tick_1024us) |=> !pin_oe[5])
        else $error("Open drain timer pin driven high.");

    chk_timer1_pulse: assert property ((s_ff.cfg[PIN_TIMER1][BIT_OUT_EN] &&
                                        s_ff.cfg[PIN_TIMER1][BIT_ALT_OUT] && !s_ff.cfg[PIN_TIMER1][BIT_OPEN_DRAIN])
                                       |=> pin_out[6] == $past(pit_irq))
        else $error("Timer pin 1 pulse wrong.");
    chk_capture_pin: assert property (!s_ff.cfg[PIN_TIMER0][BIT_OUT_EN]
                                      |=> timer_capture_in[0] == $past(s_ff.pin_s2[PIN_TIMER0]))
        else $error("Capture input not from pin.");

    chk_port_irq_gate: assert property (!s_ff.cfg[PIN_TIMER0][BIT_IRQ_EN] |=> !port_irq[PIN_TIMER0])
        else $error("Port interrupt without enable.");
    chk_serial_off: assert property (!s_ff.ctl[BIT_SER_ALT1] |=> !serial_pin_oe[1])
        else $error("Serial enable without select.");
    chk_edge_irq2_set: assert property ((s_ff.fill == 2'd3 && lvl[4] && !s_ff.prev_lvl[4]) |=> edge_irq[2])
        else $error("Edge interrupt 2 missed.");

    chk_cfg_write: assert property ((s_ff.st == PCFG_ACK && psel && penable && pwrite && pstrb[0] && !bad_addr &&
                                     idx == IDX_EDGE_IRQ0_CFG) |=> s_ff.cfg[2] == $past(pwdata[7:0] & MASK_EDGE_IRQ))
        else $error("Configuration write lost.");

endmodule

// *** dv/pcfg_board.sv ***
// Board model that works out each pin level from device drive, pull-ups and board drivers.
`timescale 1ns/1ps
module pcfg_board
(
    // Clock
    input  wire logic       pclk,
    // Device side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_up_en,
    // Board drivers
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // Pin levels
    output logic      [7:0] pin_in
);
    logic [7:0] flt;
    // A pin that nobody holds wanders every cycle, so a stale level never passes for a drive.
    always @(posedge pclk)
        flt <= (flt === 8'h55) ? 8'haa : 8'h55;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i] === 1'b1)
                pin_in[i] = pin_out[i];
            else if (ext_en[i] === 1'b1)
                pin_in[i] = ext_val[i];
            else if (pull_up_en[i] === 1'b1)
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flt[i];
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench for the port 0 pin configuration block.
`timescale 1ns/1ps
`define CK(w, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", w, e, g); end end
module tb_top;
    import pcfg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tick, pit;
    logic [7:0]  paddr, pin_in, pin_out, pin_oe, pull_up_en, ttl_sel, hs_sel, ext_val, ext_en, port_irq;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, clk_src;
    logic [1:0]  tcap, spi_oe, spi_out, ser_oe, ser_out;
    logic [2:0]  edge_irq;
    logic [7:0]  masks [7];
    int          n_mismatch, checked, ne[3], np[8], nt[2], b, bi;

    pcfg_port0 uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .ttl_sel(ttl_sel),
        .high_sink_sel(hs_sel), .clk_src(clk_src), .tick_1024us(tick), .pit_irq(pit),
        .timer_capture_in(tcap), .spi_oe(spi_oe), .spi_out(spi_out), .serial_pin_oe(ser_oe),
        .serial_pin_out(ser_out), .edge_irq(edge_irq), .port_irq(port_irq));
    pcfg_board brd (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    // ----------------
    // Clock, watchdog and pulse counters
    // ----------------
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
    always @(posedge pclk)
    begin
        for (int i = 0; i < 3; i++) if (edge_irq[i] === 1'b1) ne[i]++;
        for (int i = 0; i < 8; i++) if (port_irq[i] === 1'b1) np[i]++;
        for (int i = 0; i < 2; i++) if (pin_oe[5+i] === 1'b1 && pin_out[5+i] === 1'b1) nt[i]++;
    end

    // ----------------
    // Bus tasks
    // ----------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) n_mismatch++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic [7:0] rd;
        logic       err;
        apb(1'b1, idx, v, rd, err);
        w(3);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [7:0] e, input logic e_err, input string s);
        logic [7:0] rd;
        logic       err;
        apb(1'b0, idx, 8'h00, rd, err);
        `CK(s, e, rd)
        `CK("slave error", e_err, err)
    endtask
    task automatic pulse(input int j);
        {pit, tick} <= 2'b01 << j;
        @(posedge pclk);
        {pit, tick} <= 2'b00;
    endtask

    // ----------------
    // Tests
    // ----------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tick, pit, clk_src, spi_oe, spi_out} = '0;
        pstrb = 4'hf;
        ext_en = 8'hff;
        ext_val = 8'ha5;
        masks = '{MASK_CLOCK_IN, MASK_CLOCK_OUT, MASK_EDGE_IRQ, MASK_EDGE_IRQ, MASK_EDGE_IRQ,
                  MASK_TIMER_IO, MASK_TIMER_IO};
        w(10);
        presetn <= 1'b1;
        w(2);
        `CK("ttl at reset", 8'h00, ttl_sel)
        `CK("pull-up at reset", 8'h00, pull_up_en)
        rdc(IDX_PORT_DATA, 8'ha5, 1'b0, "pin levels");
        rdc(6'h04, 8'h00, 1'b1, "unmapped");
        for (int i = 0; i < 7; i++)
        begin
            rdc(6'(5 + i), RST_CFG, 1'b0, "config reset");
            wr(6'(5 + i), 8'hff);
            rdc(6'(5 + i), masks[i], 1'b0, "config mask");
            wr(6'(5 + i), 8'h00);
        end
        wr(IDX_CLOCK_PIN_CTRL, 8'hff);
        rdc(IDX_CLOCK_PIN_CTRL, MASK_CLOCK_CTRL, 1'b0, "control mask");
        wr(IDX_CLOCK_PIN_CTRL, 8'h00);
        pstrb <= 4'h0;
        wr(IDX_CLOCK_IN_CFG, 8'h02);
        pstrb <= 4'hf;
        rdc(IDX_CLOCK_IN_CFG, RST_CFG, 1'b0, "strobe off");
        ext_val <= 8'h00;
        $display("test register map done");
        wr(IDX_CLOCK_IN_CFG, 8'h1b);
        `CK("pull-up", 1'b1, pull_up_en[0])
        `CK("high sink", 1'b1, hs_sel[0])
        `CK("ttl", 1'b1, ttl_sel[0])
        wr(IDX_CLOCK_OUT_CFG, 8'h01);
        `CK("clock pin drive", 2'b11, pin_oe[1:0])
        wr(IDX_CLOCK_PIN_CTRL, 8'h80);
        `CK("oscillator drive", 2'b00, pin_oe[1:0])
        `CK("oscillator pull-up", 1'b0, pull_up_en[0])
        wr(IDX_CLOCK_IN_CFG, 8'h00);
        wr(IDX_CLOCK_OUT_CFG, 8'h81);
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_CLOCK_PIN_CTRL, 8'(k));
            clk_src <= 4'h1 << k;
            w(5);
            `CK("clock out high", 2'b11, {pin_oe[1], pin_out[1]})
            clk_src <= ~(4'h1 << k);
            w(5);
            `CK("clock out low", 1'b0, pin_out[1])
        end
        wr(IDX_CLOCK_OUT_CFG, 8'h01);
        clk_src <= 4'hf;
        w(5);
        `CK("clock out off", 1'b0, pin_out[1])
        wr(IDX_CLOCK_OUT_CFG, 8'h00);
        wr(IDX_CLOCK_PIN_CTRL, 8'h30);
        spi_oe <= 2'b10;
        spi_out <= 2'b01;
        w(3);
        `CK("serial drive", 4'b1001, {ser_oe, ser_out})
        wr(IDX_CLOCK_PIN_CTRL, 8'h00);
        $display("test clock and serial pins done");
        wr(IDX_PORT_DATA, 8'h08);
        wr(IDX_EDGE_IRQ1_CFG, 8'h01);
        `CK("push-pull high", 2'b11, {pin_oe[3], pin_out[3]})
        wr(IDX_EDGE_IRQ1_CFG, 8'h05);
        `CK("open drain release", 1'b0, pin_oe[3])
        wr(IDX_PORT_DATA, 8'h00);
        `CK("open drain low", 2'b10, {pin_oe[3], pin_out[3]})
        wr(IDX_EDGE_IRQ1_CFG, 8'h00);
        $display("test drivers done");
        for (int i = 0; i < 3; i++)
        begin
            b = ne[0] + ne[1] + ne[2];
            bi = ne[i];
            ext_val[2+i] <= 1'b1;
            w(6);
            `CK("rising irq", 1, ne[i] - bi)
            `CK("only one line", b + 1, ne[0] + ne[1] + ne[2])
            // The count is sampled again after the polarity write, so a stray pulse from that write is not counted.
            wr(6'(7 + i), 8'h20);
            b = ne[i];
            ext_val[2+i] <= 1'b0;
            w(6);
            `CK("falling irq", 1, ne[i] - b)
            wr(6'(7 + i), 8'h00);
        end
        wr(IDX_EDGE_IRQ0_CFG, 8'h01);
        b = ne[0];
        wr(IDX_PORT_DATA, 8'h04);
        w(4);
        `CK("written edge", 1, ne[0] - b)
        wr(IDX_PORT_DATA, 8'h00);
        wr(IDX_EDGE_IRQ0_CFG, 8'h00);
        $display("test edge lines done");
        wr(IDX_TIMER_IO0_CFG, 8'h40);
        b = np[5];
        ext_val[5] <= 1'b1;
        w(6);
        ext_val[5] <= 1'b0;
        w(6);
        `CK("input irq", 1, np[5] - b)
        wr(IDX_TIMER_IO0_CFG, 8'h41);
        wr(IDX_PORT_DATA, 8'h20);
        w(4);
        `CK("output irq", 2, np[5] - b)
        wr(IDX_TIMER_IO0_CFG, 8'h61);
        b = np[5];
        wr(IDX_PORT_DATA, 8'h00);
        w(4);
        wr(IDX_TIMER_IO0_CFG, 8'h01);
        wr(IDX_PORT_DATA, 8'h20);
        w(4);
        `CK("low-active then off", 1, np[5] - b)
        wr(IDX_PORT_DATA, 8'h00);
        $display("test port irq done");
        for (int j = 0; j < 2; j++)
        begin
            wr(6'(10 + j), 8'h00);
            ext_val[5+j] <= 1'b1;
            w(4);
            `CK("capture input", 1'b1, tcap[j])
            ext_val[5+j] <= 1'b0;
            wr(IDX_PORT_DATA, 8'(8'h20 << j));
            wr(6'(10 + j), 8'h01);
            `CK("data loop", 2'b11, {pin_out[5+j], tcap[j]})
            wr(IDX_PORT_DATA, 8'h00);
            wr(6'(10 + j), 8'h81);
            b = nt[j];
            pulse(j);
            w(5);
            `CK("timer pulse", 1, nt[j] - b)
            wr(6'(10 + j), 8'h80);
            pulse(j);
            w(5);
            `CK("no pulse as input", 1, nt[j] - b)
            wr(6'(10 + j), 8'h00);
        end
        $display("test timer pins done");
        report_and_stop();
    end
endmodule
